// [rtl/ditf_cfg.svh]
`ifndef DITF_CFG_SVH
`define DITF_CFG_SVH
// Register offsets on the plain register port.
`define DITF_A_CMD 8'h00
`define DITF_A_CFG 8'h04
`define DITF_A_COUNT 8'h08
`define DITF_A_PRE 8'h0c
`define DITF_A_DELAY 8'h10
`define DITF_A_DIV 8'h14
`define DITF_A_FILT 8'h18
`define DITF_A_RISE 8'h1c
`define DITF_A_FALL 8'h20
`define DITF_A_STAT 8'h24
`define DITF_A_DATA 8'h28
// Command and status bit positions.
`define DITF_CMD_START 0
`define DITF_CMD_STOP 1
`define DITF_STAT_OVF 5
// Reset values.
`define DITF_CFG_RST 32'h0000_0000
`define DITF_COUNT_RST 16'h0010
`define DITF_PRE_RST 16'h0000
`define DITF_DELAY_RST 16'h0000
`define DITF_DIV_RST 16'h0028
`define DITF_FILT_RST 16'h0001
`define DITF_CD_RST 8'h00
// Source index of the analog comparison event.
`define DITF_ACMP_IDX 3'h7
// Filter step and clock period in ns, and the step in clock cycles.
`define DITF_STEP_NS 25
`define DITF_CLK_NS 25
`define DITF_STEP_CYC ((`DITF_STEP_NS + `DITF_CLK_NS - 1) / `DITF_CLK_NS)
`endif

// [rtl/ditf_pkg.sv]
package ditf_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_ARM, ST_DELAY, ST_ACQ, ST_POST} ditf_state_t;
    typedef struct packed {
        logic [6:0] rsvd;
        logic ref_inv;
        logic [1:0] route;
        logic route_en;
        logic filt_en;
        logic buffered;
        logic [1:0] clk_src;
        logic samp_fall;
        logic pause_en;
        logic pause_low;
        logic [2:0] pause_src;
        logic ref_fall;
        logic [2:0] ref_src;
        logic start_fall;
        logic [2:0] start_src;
        logic start_en;
        logic ref_en;
        logic finite;
    } ditf_cfg_t;
endpackage

// [rtl/ditf_top.sv]
// Summary of operation
// - Start on trigger, else software start.
// - Finite count, reference, or software stop ends.
// - Delay start to first internal sample.
// - Selectable digital start source and edge.
// - Analog start uses first rising edge.
// - Routed start trigger is active-high pulse.
// - Posttrigger count is buffer minus pretrigger.
// - Reference ignored until pretrigger samples captured.
// - Full buffer drops oldest while awaiting reference.
// - Collect posttrigger samples, then end.
// - Selectable reference source and edge.
// - Routed reference active high unless inverted.
// - Internal sample clock halts while paused.
// - Pause is level sensitive only.
// - Analog pause polarity set by configuration.
// - One shared debounce filter per module.
// - Minimum width in 25 ns steps.
// - Pulses under half width always rejected.
// - Pass level after two consecutive samples.
// - Per-line edge selects; edge samples all lines.
// - Change detection event drives routable output.
// - Buffered uses FIFO; nonbuffered passes singly.
// - Sample into full FIFO flags overflow.
// - Capture on configured sample clock edge.
//
// Our own choices: the strobed register port and the placing of the registers.
`include "ditf_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module ditf_top (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    output logic [31:0] bus_rdata_out,
    input wire logic [3:0] term_in,
    input wire logic [1:0] counter_in,
    input wire logic misc_in,
    input wire logic acmp_in,
    input wire logic ext_clk_in,
    input wire logic [7:0] di_in,
    output logic term_out,
    output logic term_oe_out,
    output logic edge_seen_event_out,
    output logic input_sample_strobe_out
);
    localparam int DEPTH = 16;
    ditf_pkg::ditf_cfg_t cfg_q;
    ditf_pkg::ditf_state_t state_q;
    logic [16:0] sy1_q, sy2_q;
    logic [7:0] di_s, src_s, src_prev_q;
    logic ext_s, ext_prev_q;
    logic [15:0] count_q, pre_q, delay_q, div_q, filt_q;
    logic [7:0] rise_q, fall_q;
    logic start_cmd, stop_cmd, start_hit, ref_hit, paused, ext_hit;
    logic [31:0] tp_cyc;
    logic [15:0] half_cyc, fdiv_q, sdiv_q, dly_q, cnt_q, post_q, post_tgt;
    logic ftick, int_tick, collecting, strobe, edge_any, armed;
    logic [7:0] fs_q, fo_q, fo_prev_q;
    logic [7:0] mem_q [DEPTH];
    logic [3:0] wp_q, rp_q;
    logic [4:0] lvl_q, depth_lim;
    logic full, pop, push_ok, drop, ovf_set, ovf_q, done_q, trig_q;
    logic start_pulse, ref_pulse;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    // Every pin-side input passes two flip-flops before use.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            sy1_q <= 17'h00000;
            sy2_q <= 17'h00000;
        end else begin
            sy1_q <= {ext_clk_in, acmp_in, misc_in, counter_in, term_in, di_in};
            sy2_q <= sy1_q;
        end
    end
    assign di_s = sy2_q[7:0];
    assign src_s = sy2_q[15:8];
    assign ext_s = sy2_q[16];

    // Previous source levels for edge detection.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            src_prev_q <= 8'h00;
            ext_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_s;
            ext_prev_q <= ext_s;
        end
    end

    // Picks the selected edge of one source out of the source vector.
    function automatic logic pick_edge(input logic [7:0] now, input logic [7:0] prev,
                                       input logic [2:0] sel, input logic fall);
        pick_edge = fall ? (prev[sel] & ~now[sel]) : (now[sel] & ~prev[sel]);
    endfunction

    // The analog event always starts on its rising edge.
    assign start_hit = pick_edge(src_s, src_prev_q, cfg_q.start_src,
        cfg_q.start_fall && (cfg_q.start_src != `DITF_ACMP_IDX));
    assign ref_hit = pick_edge(src_s, src_prev_q, cfg_q.ref_src, cfg_q.ref_fall);
    // Pause looks only at the present level, with selectable polarity.
    assign paused = cfg_q.pause_en
        && (src_s[cfg_q.pause_src] ^ cfg_q.pause_low);
    assign ext_hit = cfg_q.samp_fall ? (ext_prev_q & ~ext_s) : (ext_s & ~ext_prev_q);

    // Command decode; the command word is write-only.
    assign start_cmd = bus_wr_in && (bus_addr_in == `DITF_A_CMD)
        && bus_wdata_in[`DITF_CMD_START];
    assign stop_cmd = bus_wr_in && (bus_addr_in == `DITF_A_CMD)
        && bus_wdata_in[`DITF_CMD_STOP];

    // Configuration registers written by software.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cfg_q <= `DITF_CFG_RST;
            count_q <= `DITF_COUNT_RST;
            pre_q <= `DITF_PRE_RST;
            delay_q <= `DITF_DELAY_RST;
            div_q <= `DITF_DIV_RST;
            filt_q <= `DITF_FILT_RST;
            rise_q <= `DITF_CD_RST;
            fall_q <= `DITF_CD_RST;
        end else if (bus_wr_in) begin
            case (bus_addr_in)
                `DITF_A_CFG: cfg_q <= bus_wdata_in;
                `DITF_A_COUNT: count_q <= bus_wdata_in[15:0];
                `DITF_A_PRE: pre_q <= bus_wdata_in[15:0];
                `DITF_A_DELAY: delay_q <= bus_wdata_in[15:0];
                `DITF_A_DIV: div_q <= bus_wdata_in[15:0];
                `DITF_A_FILT: filt_q <= bus_wdata_in[15:0];
                `DITF_A_RISE: rise_q <= bus_wdata_in[7:0];
                `DITF_A_FALL: fall_q <= bus_wdata_in[7:0];
                default: cfg_q <= cfg_q;
            endcase
        end
    end

    // The filter clock runs at half the minimum width, at least one cycle.
    assign tp_cyc = 32'(filt_q) * 32'(`DITF_STEP_CYC);
    assign half_cyc = (tp_cyc[16:1] == 16'h0000) ? 16'h0001 : tp_cyc[16:1];
    assign ftick = (fdiv_q >= half_cyc - 16'h0001);

    // Filter clock divider shared by all lines of the module.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || ftick) begin
            fdiv_q <= 16'h0000;
        end else begin
            fdiv_q <= fdiv_q + 16'h0001;
        end
    end

    // Per-line debounce and edge detection, one shared filter setting for all lines.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_line
            always_ff @(posedge ref_clk_in) begin
                if (reset_in) begin
                    fs_q[gi] <= 1'b0;
                    fo_q[gi] <= 1'b0;
                    fo_prev_q[gi] <= 1'b0;
                end else begin
                    fo_prev_q[gi] <= fo_q[gi];
                    if (!cfg_q.filt_en) begin
                        fo_q[gi] <= di_s[gi];
                    end else if (ftick) begin
                        fs_q[gi] <= di_s[gi];
                        // A level passes once two filter samples agree.
                        if (di_s[gi] == fs_q[gi]) begin
                            fo_q[gi] <= di_s[gi];
                        end
                    end
                end
            end
        end
    endgenerate

    // Any enabled edge on any line, task line or not, asks for a sample.
    assign edge_any = |((rise_q & fo_q & ~fo_prev_q) | (fall_q & ~fo_q & fo_prev_q));

    // Internal sample divider; it stands still while paused.
    assign int_tick = collecting && !paused && (sdiv_q >= div_q - 16'h0001);
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !collecting || int_tick) begin
            sdiv_q <= 16'h0000;
        end else if (!paused) begin
            sdiv_q <= sdiv_q + 16'h0001;
        end
    end

    assign collecting = (state_q == ditf_pkg::ST_ACQ) || (state_q == ditf_pkg::ST_POST);
    always_comb begin
        case (cfg_q.clk_src)
            2'h0: strobe = int_tick;
            2'h1: strobe = collecting && ext_hit;
            default: strobe = collecting && edge_any;
        endcase
    end

    assign armed = (cnt_q >= pre_q);
    assign post_tgt = count_q - pre_q;

    // Acquisition sequencer.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_q <= ditf_pkg::ST_IDLE;
            dly_q <= 16'h0000;
            cnt_q <= 16'h0000;
            post_q <= 16'h0000;
            done_q <= 1'b0;
            trig_q <= 1'b0;
        end else if (stop_cmd) begin
            state_q <= ditf_pkg::ST_IDLE;
        end else begin
            case (state_q)
                ditf_pkg::ST_IDLE: begin
                    if (start_cmd) begin
                        state_q <= cfg_q.start_en ? ditf_pkg::ST_ARM
                                                  : ditf_pkg::ST_DELAY;
                        dly_q <= 16'h0000;
                        cnt_q <= 16'h0000;
                        post_q <= 16'h0000;
                        done_q <= 1'b0;
                        trig_q <= 1'b0;
                    end
                end
                ditf_pkg::ST_ARM: begin
                    if (start_hit) begin
                        state_q <= ditf_pkg::ST_DELAY;
                    end
                end
                ditf_pkg::ST_DELAY: begin
                    // The delay only applies to the internal sample clock.
                    if (cfg_q.clk_src != 2'h0 || dly_q >= delay_q) begin
                        state_q <= ditf_pkg::ST_ACQ;
                    end else begin
                        dly_q <= dly_q + 16'h0001;
                    end
                end
                ditf_pkg::ST_ACQ: begin
                    if (cfg_q.finite && cfg_q.ref_en && armed && ref_hit) begin
                        trig_q <= 1'b1;
                        state_q <= (post_tgt == 16'h0000) ? ditf_pkg::ST_IDLE
                                                          : ditf_pkg::ST_POST;
                        done_q <= (post_tgt == 16'h0000);
                    end else if (strobe) begin
                        cnt_q <= cnt_q + 16'h0001;
                        if (cfg_q.finite && !cfg_q.ref_en
                            && (cnt_q + 16'h0001 >= count_q)) begin
                            state_q <= ditf_pkg::ST_IDLE;
                            done_q <= 1'b1;
                        end
                    end
                end
                ditf_pkg::ST_POST: begin
                    if (strobe) begin
                        post_q <= post_q + 16'h0001;
                        if (post_q + 16'h0001 >= post_tgt) begin
                            state_q <= ditf_pkg::ST_IDLE;
                            done_q <= 1'b1;
                        end
                    end
                end
                default: state_q <= ditf_pkg::ST_IDLE;
            endcase
        end
    end

    // Nonbuffered mode keeps a single sample for the host.
    assign depth_lim = cfg_q.buffered ? 5'h10 : 5'h01;
    assign full = (lvl_q >= depth_lim);
    assign pop = bus_rd_in && (bus_addr_in == `DITF_A_DATA) && (lvl_q != 5'h00);
    assign push_ok = strobe && (!full || pop || (collecting && cfg_q.ref_en));
    assign drop = strobe && full && !pop && collecting && cfg_q.ref_en;
    assign ovf_set = strobe && full && !pop && !drop;

    // Sample store; in reference mode the oldest entry goes when the ring is full.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || (state_q == ditf_pkg::ST_IDLE && start_cmd)) begin
            wp_q <= 4'h0;
            rp_q <= 4'h0;
            lvl_q <= 5'h00;
        end else begin
            if (push_ok) begin
                mem_q[wp_q] <= fo_q;
                wp_q <= wp_q + 4'h1;
            end
            if (pop || drop) begin
                rp_q <= rp_q + 4'h1;
            end
            lvl_q <= lvl_q + {4'h0, push_ok} - {4'h0, (pop || drop)};
        end
    end

    // Overflow is sticky; a new overflow wins over a clear.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ovf_q <= 1'b0;
        end else if (ovf_set) begin
            ovf_q <= 1'b1;
        end else if (bus_wr_in && bus_addr_in == `DITF_A_STAT
                     && bus_wdata_in[`DITF_STAT_OVF]) begin
            ovf_q <= 1'b0;
        end
    end

    // Read data stand for exactly the cycle after the read strobe.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !bus_rd_in) begin
            bus_rdata_out <= 32'h0000_0000;
        end else begin
            case (bus_addr_in)
                `DITF_A_CFG: bus_rdata_out <= cfg_q;
                `DITF_A_COUNT: bus_rdata_out <= {16'h0000, count_q};
                `DITF_A_PRE: bus_rdata_out <= {16'h0000, pre_q};
                `DITF_A_DELAY: bus_rdata_out <= {16'h0000, delay_q};
                `DITF_A_DIV: bus_rdata_out <= {16'h0000, div_q};
                `DITF_A_FILT: bus_rdata_out <= {16'h0000, filt_q};
                `DITF_A_RISE: bus_rdata_out <= {24'h000000, rise_q};
                `DITF_A_FALL: bus_rdata_out <= {24'h000000, fall_q};
                `DITF_A_STAT: bus_rdata_out <= {16'h0000, cnt_q[7:0], collecting, armed,
                                                ovf_q, trig_q, done_q, lvl_q[2:0]};
                `DITF_A_DATA: bus_rdata_out <= {19'h00000, lvl_q, mem_q[rp_q]};
                default: bus_rdata_out <= 32'h0000_0000;
            endcase
        end
    end

    assign start_pulse = (state_q == ditf_pkg::ST_ARM && start_hit)
        || (state_q == ditf_pkg::ST_IDLE && start_cmd && !cfg_q.start_en);
    assign ref_pulse = (state_q == ditf_pkg::ST_ACQ) && cfg_q.finite && cfg_q.ref_en
        && armed && ref_hit;

    // Registered event outputs and the routed terminal.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            term_out <= 1'b0;
            term_oe_out <= 1'b0;
            edge_seen_event_out <= 1'b0;
            input_sample_strobe_out <= 1'b0;
        end else begin
            edge_seen_event_out <= edge_any;
            input_sample_strobe_out <= strobe;
            term_oe_out <= cfg_q.route_en;
            case (cfg_q.route)
                2'h0: term_out <= start_pulse;
                2'h1: term_out <= ref_pulse ^ cfg_q.ref_inv;
                2'h2: term_out <= edge_any;
                default: term_out <= strobe;
            endcase
        end
    end

    start_arm_a: assert property (state_q == ditf_pkg::ST_IDLE && start_cmd && !stop_cmd
        && cfg_q.start_en |=> state_q == ditf_pkg::ST_ARM)
        else $error("start with trigger did not arm");
    stop_idle_a: assert property (stop_cmd |=> state_q == ditf_pkg::ST_IDLE)
        else $error("stop command did not end acquisition");
    delay_len_a: assert property ($rose(state_q == ditf_pkg::ST_ACQ) && cfg_q.clk_src == 2'h0
        |-> $past(dly_q) >= delay_q)
        else $error("start delay cut short");
    start_edge_a: assert property (state_q == ditf_pkg::ST_ARM && start_hit && !stop_cmd
        |=> state_q == ditf_pkg::ST_DELAY)
        else $error("start edge missed");
    ref_ignore_a: assert property (state_q == ditf_pkg::ST_ACQ && !armed
        |=> state_q != ditf_pkg::ST_POST)
        else $error("reference taken before pretrigger count");
    post_end_a: assert property (state_q == ditf_pkg::ST_POST && strobe && !stop_cmd
        && post_q + 16'h0001 >= post_tgt |=> state_q == ditf_pkg::ST_IDLE && done_q)
        else $error("posttrigger collection did not end");
    drop_old_a: assert property (drop |=> lvl_q == $past(lvl_q))
        else $error("circular drop changed level");
    pause_hold_a: assert property (paused && cfg_q.clk_src == 2'h0 |-> !strobe)
        else $error("internal sample while paused");
    filt_pass_a: assert property (cfg_q.filt_en && $past(cfg_q.filt_en)
        |-> ((fo_q ^ $past(fo_q)) & (fo_q ^ $past(fs_q))) == 8'h00)
        else $error("filter passed an unconfirmed level");
    ovf_flag_a: assert property (ovf_set |=> ovf_q)
        else $error("overflow not flagged");
    edge_evt_a: assert property (edge_any |=> edge_seen_event_out)
        else $error("change event not raised");
endmodule
`default_nettype wire

// [dv/ditf_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ditf_far_model (
    input wire logic clk_in,
    output logic [3:0] term_out,
    output logic [1:0] counter_out,
    output logic misc_out,
    output logic acmp_out,
    output logic ext_clk_out,
    output logic [7:0] di_out
);
    // Terminals rest low and the lines at 5a; the external sample clock stands still outside use.
    initial begin
        term_out = 4'h0;
        counter_out = 2'h0;
        misc_out = 1'b0;
        acmp_out = 1'b0;
        ext_clk_out = 1'b0;
        di_out = 8'h5a;
    end
    // Moves terminal, comparison and line levels just after a clock edge and holds them.
    task automatic drive(input logic [3:0] t, input logic a, input logic [7:0] d);
        @(posedge clk_in);
        term_out <= t;
        acmp_out <= a;
        di_out <= d;
    endtask
endmodule
`default_nettype wire

// [dv/ditf_top_tb.sv]
`include "ditf_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module ditf_top_tb;
    logic ref_clk, rst, wr, rd, misc, acmp, ext, term_o, oe, ev, ss;
    logic [7:0] addr, di;
    logic [31:0] wdata, rdata, v;
    logic [3:0] term;
    logic [1:0] ctr;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n_ss = 0;
    int n_ev = 0;
    int n_tp = 0;
    int n0, n1, e0, t0;
    ditf_pkg::ditf_cfg_t c;
    localparam logic [7:0] RA [10] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
        8'h00, 8'h3c};
    localparam logic [15:0] RV [10] = '{16'h0, 16'h10, 16'h0, 16'h0, 16'h28, 16'h1, 16'h0,
        16'h0, 16'h0, 16'h0};

    ditf_top u_ditf_top (.ref_clk_in(ref_clk), .reset_in(rst), .bus_addr_in(addr),
        .bus_wdata_in(wdata), .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata),
        .term_in(term), .counter_in(ctr), .misc_in(misc), .acmp_in(acmp), .ext_clk_in(ext),
        .di_in(di), .term_out(term_o), .term_oe_out(oe), .edge_seen_event_out(ev),
        .input_sample_strobe_out(ss));
    ditf_far_model u_ditf_far_model (.clk_in(ref_clk), .term_out(term), .counter_out(ctr),
        .misc_out(misc), .acmp_out(acmp), .ext_clk_out(ext), .di_out(di));

    // The clock toggles every half period of 25 ns.
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Counts strobes, events and routed pulses, and cuts a hung run short.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (ss === 1'b1)
            n_ss <= n_ss + 1;
        if (ev === 1'b1)
            n_ev <= n_ev + 1;
        if (term_o === 1'b1)
            n_tp <= n_tp + 1;
        if (cycles == 30000) begin
            fail_count++;
            stop_test();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One-cycle register write.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // One-cycle register read; the data is taken in the following cycle.
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Loads counts and configuration, issues a start and notes the counters.
    task automatic run(input logic [15:0] cnt, input logic [15:0] pre, input logic [15:0] div);
        wr_reg(`DITF_A_COUNT, {16'h0, cnt});
        wr_reg(`DITF_A_PRE, {16'h0, pre});
        wr_reg(`DITF_A_DIV, {16'h0, div});
        wr_reg(`DITF_A_CFG, c);
        wr_reg(`DITF_A_CMD, 32'h1);
        n0 = n_ss;
        e0 = n_ev;
        t0 = n_tp;
    endtask

    // Polls the status word until the done bit shows, within a bounded count.
    task automatic wait_done();
        v = 32'h0;
        for (int i = 0; i < 300 && v[3] !== 1'b1; i++)
            rd_reg(`DITF_A_STAT, v);
    endtask

    // Waits, within a bound, until k samples have been taken since the start.
    task automatic wait_ss(input int k);
        for (int i = 0; i < 500 && n_ss < n0 + k; i++)
            @(posedge ref_clk);
    endtask

    // Main sequence.
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        c = '0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        // Reset values, the write-only command word and an unmapped address.
        for (int i = 0; i < 10; i++) begin
            rd_reg(RA[i], v);
            `CHK(v, {16'h0, RV[i]})
        end
        // Software start with a delay before the first internal sample.
        c.finite = 1'b1;
        c.buffered = 1'b1;
        wr_reg(`DITF_A_DELAY, 32'h14);
        run(16'h2, 16'h0, 16'h2);
        repeat (20) @(posedge ref_clk);
        `CHK(n_ss - n0, 0)
        wait_done();
        `CHK(n_ss - n0, 2)
        rd_reg(`DITF_A_STAT, v);
        `CHK(v[2:0], 3'h2)
        rd_reg(`DITF_A_DATA, v);
        `CHK(v[12:0], {5'h2, 8'h5a})
        rd_reg(`DITF_A_DATA, v);
        `CHK(v[12:0], {5'h1, 8'h5a})
        // Terminal start on the falling edge, routed out as a pulse.
        wr_reg(`DITF_A_DELAY, 32'h0);
        c.start_en = 1'b1;
        c.start_src = 3'h1;
        c.start_fall = 1'b1;
        c.route_en = 1'b1;
        run(16'h2, 16'h0, 16'h2);
        u_ditf_far_model.drive(4'h2, 1'b0, 8'h5a);
        repeat (12) @(posedge ref_clk);
        `CHK(n_ss - n0, 0)
        u_ditf_far_model.drive(4'h0, 1'b0, 8'h5a);
        wait_done();
        `CHK(n_ss - n0, 2)
        `CHK(n_tp - t0, 1)
        `CHK(oe, 1'b1)
        // Analog start fires on the rising edge whatever the edge selection says.
        c.start_src = `DITF_ACMP_IDX;
        run(16'h2, 16'h0, 16'h2);
        repeat (12) @(posedge ref_clk);
        `CHK(n_ss - n0, 0)
        u_ditf_far_model.drive(4'h0, 1'b1, 8'h5a);
        wait_done();
        `CHK(n_ss - n0, 2)
        u_ditf_far_model.drive(4'h0, 1'b0, 8'h5a);
        // Reference stop: an early edge is ignored, then buffer minus pretrigger samples.
        c.start_en = 1'b0;
        c.ref_en = 1'b1;
        c.ref_src = 3'h0;
        c.route = 2'h1;
        run(16'h4, 16'h2, 16'h8);
        u_ditf_far_model.drive(4'h1, 1'b0, 8'h5a);
        u_ditf_far_model.drive(4'h0, 1'b0, 8'h5a);
        wait_ss(5);
        rd_reg(`DITF_A_STAT, v);
        `CHK(v[4:3], 2'h0)
        wait_ss(6);
        n1 = n_ss;
        u_ditf_far_model.drive(4'h1, 1'b0, 8'h5a);
        wait_done();
        `CHK(n_ss - n1, 2)
        `CHK(v[4], 1'b1)
        `CHK(n_tp - t0, 1)
        u_ditf_far_model.drive(4'h0, 1'b0, 8'h5a);
        // A full ring keeps dropping its oldest entry through the posttrigger phase.
        run(16'h4, 16'h2, 16'h2);
        wait_ss(20);
        u_ditf_far_model.drive(4'h1, 1'b0, 8'h5a);
        wait_done();
        `CHK(v[`DITF_STAT_OVF], 1'b0)
        rd_reg(`DITF_A_DATA, v);
        `CHK(v[12:8], 5'h10)
        u_ditf_far_model.drive(4'h0, 1'b0, 8'h5a);
        // Level pause on terminal 2, then a software stop in continuous mode.
        c = '0;
        c.buffered = 1'b1;
        c.pause_en = 1'b1;
        c.pause_src = 3'h2;
        run(16'h10, 16'h0, 16'h8);
        wait_ss(1);
        u_ditf_far_model.drive(4'h4, 1'b0, 8'h5a);
        repeat (10) @(posedge ref_clk);
        n1 = n_ss;
        repeat (40) @(posedge ref_clk);
        `CHK(n_ss - n1, 0)
        u_ditf_far_model.drive(4'h0, 1'b0, 8'h5a);
        repeat (40) @(posedge ref_clk);
        `CHK(n_ss > n1, 1'b1)
        wr_reg(`DITF_A_CMD, 32'h2);
        repeat (4) @(posedge ref_clk);
        n1 = n_ss;
        repeat (40) @(posedge ref_clk);
        `CHK(n_ss - n1, 0)
        // Unbuffered sampling overflows at once; a status write clears the flag.
        c = '0;
        run(16'h10, 16'h0, 16'h4);
        wait_ss(3);
        rd_reg(`DITF_A_STAT, v);
        `CHK(v[`DITF_STAT_OVF], 1'b1)
        wr_reg(`DITF_A_CMD, 32'h2);
        wr_reg(`DITF_A_STAT, 32'h20);
        rd_reg(`DITF_A_STAT, v);
        `CHK(v[`DITF_STAT_OVF], 1'b0)
        // Filtered change detection on line 0: a short glitch dies, long pulses pass.
        c.buffered = 1'b1;
        c.filt_en = 1'b1;
        c.clk_src = 2'h2;
        wr_reg(`DITF_A_FILT, 32'h8);
        wr_reg(`DITF_A_RISE, 32'h1);
        run(16'h10, 16'h0, 16'h8);
        u_ditf_far_model.drive(4'h0, 1'b0, 8'h5b);
        repeat (2) @(posedge ref_clk);
        u_ditf_far_model.drive(4'h0, 1'b0, 8'h5a);
        repeat (30) @(posedge ref_clk);
        `CHK(n_ev - e0, 0)
        u_ditf_far_model.drive(4'h0, 1'b0, 8'h5b);
        repeat (30) @(posedge ref_clk);
        u_ditf_far_model.drive(4'h0, 1'b0, 8'h5a);
        repeat (30) @(posedge ref_clk);
        `CHK(n_ev - e0, 1)
        `CHK(n_ss - n0, 1)
        rd_reg(`DITF_A_DATA, v);
        `CHK(v[7:0], 8'h5b)
        wr_reg(`DITF_A_FALL, 32'h1);
        u_ditf_far_model.drive(4'h0, 1'b0, 8'h5b);
        repeat (30) @(posedge ref_clk);
        u_ditf_far_model.drive(4'h0, 1'b0, 8'h5a);
        repeat (30) @(posedge ref_clk);
        `CHK(n_ev - e0, 3)
        wr_reg(`DITF_A_CMD, 32'h2);
        stop_test();
    end
endmodule
`default_nettype wire
